// file: verilog/gate_ctrl_defines.vh
`ifndef GATE_CTRL_DEFINES_VH
`define GATE_CTRL_DEFINES_VH

// ----------------------------------------------------------------
// Clock and timing (times in ns, counts in 125 MHz cycles)
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define DEAD_TIME_NS 1500
`define MIN_PULSE_NS 500
`define MIN_PERIOD_NS 50000
`define FAULT_REACT_NS 20000
`define SHUTDOWN_PULSE_NS 6000
// Least times round up
`define DEAD_CYC ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYC ((`MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PERIOD_CYC ((`MIN_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHDN_CYC ((`SHUTDOWN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Longest time rounds down
`define REACT_CYC (`FAULT_REACT_NS / `CLK_PERIOD_NS)

`define CNT_W 16
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001

// ----------------------------------------------------------------
// Per-phase state codes
// ----------------------------------------------------------------
`define PH_W 2
`define PH_OFF 2'h0
`define PH_HIGH 2'h1
`define PH_LOW 2'h2

`endif

// file: verilog/gate_ctrl.v
`include "gate_ctrl_defines.vh"

// Behaviour
// - Leave at least 1.5 us between one command falling and other rising.
// - Every high and low command interval lasts at least 0.5 us, except where a stop cuts it short.
// - Command carrier frequency stays at or below 20 kHz, except where a stop cuts a cycle short.
// - Command outputs are always actively driven, never high impedance.
// - After fault line falls, drive all commands low within 20 us; with clk_en_i low the commands hold their last state.
// - On fault, stop all three phases.
// - Controller-forced fault line low pulses last at least 6 us.
module gate_ctrl (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire clk_en_i,
    input wire run_i,
    input wire [2:0] high_req_i,
    input wire shutdown_req_i,
    input wire fault_clear_i,
    input wire fault_line_i,
    input wire current_limit_flag_i,
    output reg [2:0] high_side_cmd_o,
    output reg [2:0] low_side_cmd_o,
    output reg fault_line_o,
    output reg fault_line_oe_o,
    output reg high_side_shutdown_in_o,
    output reg fault_latched_o,
    output reg shutdown_busy_o
);

    // ------------------------------------------------------------
    // Constants and helpers
    // ------------------------------------------------------------
    // Counts are sized once here so every load below is a plain
    // copy of the counter's own width; the largest, the dwell of
    // 3125 cycles, fits in 16 bits with a wide margin.
    localparam [`CNT_W-1:0] DEAD_LOAD = `DEAD_CYC;
    localparam [`CNT_W-1:0] DWELL_LOAD = `PERIOD_CYC / 2;
    localparam [`CNT_W-1:0] SHDN_LOAD = `SHDN_CYC;

    // Phase states; OFF is the only state with both commands low
    localparam [`PH_W-1:0] ST_OFF = `PH_OFF;
    localparam [`PH_W-1:0] ST_HIGH = `PH_HIGH;
    localparam [`PH_W-1:0] ST_LOW = `PH_LOW;

    // True once a down-counter has run out
    function cnt_done;
        input [`CNT_W-1:0] cnt;
        begin
            cnt_done = (cnt == `CNT_ZERO);
        end
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Both pins move with no regard to our clock, so only the second
    // stage is ever read. The fault stage resets high, the line's idle
    // level, so leaving reset never looks like a fault.
    reg fault_meta_ff;
    reg fault_sync_ff;
    reg ocl_meta_ff;
    reg ocl_sync_ff;

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fault_meta_ff <= 1'b1;
            fault_sync_ff <= 1'b1;
            ocl_meta_ff <= 1'b0;
            ocl_sync_ff <= 1'b0;
        end else if (clk_en_i) begin
            fault_meta_ff <= fault_line_i;
            fault_sync_ff <= fault_meta_ff;
            ocl_meta_ff <= current_limit_flag_i;
            ocl_sync_ff <= ocl_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Fault latch and forced low-side shutdown pulse
    // ------------------------------------------------------------
    reg [`CNT_W-1:0] shdn_cnt_ff;
    // The synchronised line is low during our own pulse too; latching
    // then is harmless and keeps the phases stopped until cleared.
    wire fault_seen = ~fault_sync_ff;
    wire stop_all = fault_seen | fault_latched_o | ~run_i;
    // A request that arrives while a pulse runs is dropped, not
    // queued; a request held high restarts the pulse once it ends.
    wire shdn_idle = cnt_done(shdn_cnt_ff);
    wire shdn_start = shutdown_req_i & shdn_idle;

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fault_latched_o <= 1'b0;
            shdn_cnt_ff <= `CNT_ZERO;
            fault_line_o <= 1'b0;
            fault_line_oe_o <= 1'b0;
            shutdown_busy_o <= 1'b0;
            high_side_shutdown_in_o <= 1'b0;
        end else if (clk_en_i) begin
            // Set wins over clear: a fault seen in the clearing cycle
            // stays latched, and a clear while the line is low is void
            if (fault_seen)
                fault_latched_o <= 1'b1;
            else if (fault_clear_i)
                fault_latched_o <= 1'b0;
            // The count loads on the request and then runs on its own,
            // whatever the request does meanwhile
            if (!shdn_idle) begin
                shdn_cnt_ff <= shdn_cnt_ff - `CNT_ONE;
            end else if (shutdown_req_i) begin
                shdn_cnt_ff <= SHDN_LOAD;
            end
            // Open drain: only ever sink, the pull-up gives the high
            fault_line_o <= 1'b0;
            fault_line_oe_o <= !shdn_idle | shdn_start;
            shutdown_busy_o <= !shdn_idle | shutdown_req_i;
            // Route the current-limit flag to the high-side shutdown;
            // stops raise it too, so high sides do not rely on edges
            high_side_shutdown_in_o <= ocl_sync_ff | stop_all;
        end
    end

    // ------------------------------------------------------------
    // Per-phase command sequencer
    // ------------------------------------------------------------
    // Each phase toggles between HIGH and LOW through an OFF dead
    // interval. Dead time exceeds the minimum pulse, so every low
    // interval is long enough; HIGH/LOW dwell is at least half the
    // least period, which holds the carrier at or under 20 kHz.
    reg [`PH_W-1:0] ph_state_ff [0:2];
    reg [`CNT_W-1:0] ph_cnt_ff [0:2];
    // Remembers which side the dwell belongs to, so a request that
    // flips and flips back within the dwell causes no swap
    reg want_high_ff [0:2];

    // Clock enable low holds every counter and command where it is, so
    // a frozen controller keeps the driver in its last state.
    integer i;
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            for (i = 0; i < 3; i = i + 1) begin
                ph_state_ff[i] <= ST_OFF;
                ph_cnt_ff[i] <= DEAD_LOAD;
                want_high_ff[i] <= 1'b0;
            end
            high_side_cmd_o <= 3'h0;
            low_side_cmd_o <= 3'h0;
        end else if (clk_en_i) begin
            for (i = 0; i < 3; i = i + 1) begin
                // Counters run down to zero and rest there
                if (!cnt_done(ph_cnt_ff[i]))
                    ph_cnt_ff[i] <= ph_cnt_ff[i] - `CNT_ONE;
                if (stop_all) begin
                    // Registered next cycle: well inside 20 us.
                    // A stop may cut a command short; fault safety
                    // outranks the least pulse width, and the reload
                    // still gives a full dead interval afterwards.
                    ph_state_ff[i] <= ST_OFF;
                    ph_cnt_ff[i] <= DEAD_LOAD;
                    high_side_cmd_o[i] <= 1'b0;
                    low_side_cmd_o[i] <= 1'b0;
                end else begin
                    case (ph_state_ff[i])
                        ST_OFF: begin
                            // Dead interval over: take the request
                            // and turn on exactly one side
                            if (cnt_done(ph_cnt_ff[i])) begin
                                want_high_ff[i] <= high_req_i[i];
                                ph_cnt_ff[i] <= DWELL_LOAD;
                                if (high_req_i[i]) begin
                                    ph_state_ff[i] <= ST_HIGH;
                                    high_side_cmd_o[i] <= 1'b1;
                                end else begin
                                    ph_state_ff[i] <= ST_LOW;
                                    low_side_cmd_o[i] <= 1'b1;
                                end
                            end
                        end
                        ST_HIGH, ST_LOW: begin
                            // A changed request waits out the dwell,
                            // then both sides drop before the swap
                            if (cnt_done(ph_cnt_ff[i]) &&
                                high_req_i[i] != want_high_ff[i]) begin
                                ph_state_ff[i] <= ST_OFF;
                                ph_cnt_ff[i] <= DEAD_LOAD;
                                high_side_cmd_o[i] <= 1'b0;
                                low_side_cmd_o[i] <= 1'b0;
                            end
                        end
                        default: begin
                            // Unused code: fall back to off, both low
                            ph_state_ff[i] <= ST_OFF;
                            ph_cnt_ff[i] <= DEAD_LOAD;
                            high_side_cmd_o[i] <= 1'b0;
                            low_side_cmd_o[i] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

endmodule // gate_ctrl

// file: test/gate_ctrl_props.sv
module gate_ctrl_props (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire clk_en_i,
    input wire run_i,
    input wire fault_line_i,
    input wire current_limit_flag_i,
    input wire [2:0] high_side_cmd_o,
    input wire [2:0] low_side_cmd_o,
    input wire fault_line_o,
    input wire fault_line_oe_o,
    input wire high_side_shutdown_in_o,
    input wire fault_latched_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i || !clk_en_i);
    reg [15:0] oe_len_ff;
    always @(posedge sys_clk_i) begin
        oe_len_ff <= fault_line_oe_o ? oe_len_ff + 16'h0001 : 16'h0000;
    end
    a_no_overlap: assert property ((high_side_cmd_o & low_side_cmd_o) == 3'h0)
        else $error("both commands of a phase high");
    a_dead_low: assert property ($rose(low_side_cmd_o[0]) |->
        !$past(high_side_cmd_o[0], 188)) else $error("dead time short");
    a_dead_high: assert property ($rose(high_side_cmd_o[1]) |->
        !$past(low_side_cmd_o[1], 188)) else $error("dead time short");
    a_fault_stop: assert property (!fault_line_i |-> ##[1:3]
        (high_side_cmd_o | low_side_cmd_o) == 3'h0) else $error("no stop");
    a_fault_latch: assert property (!fault_line_i |-> ##3 fault_latched_o)
        else $error("fault not latched");
    a_run_stop: assert property (!run_i |-> ##[1:3]
        (high_side_cmd_o | low_side_cmd_o) == 3'h0) else $error("run low");
    a_pulse_len: assert property ($fell(fault_line_oe_o) |->
        oe_len_ff >= 16'h02EF) else $error("forced pulse short");
    a_sink_low: assert property (fault_line_oe_o |-> !fault_line_o)
        else $error("fault line driven high");
    a_limit_shdn: assert property (current_limit_flag_i |-> ##[1:3]
        high_side_shutdown_in_o) else $error("shutdown not raised");
endmodule // gate_ctrl_props

bind gate_ctrl gate_ctrl_props props (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .run_i(run_i), .fault_line_i(fault_line_i),
    .current_limit_flag_i(current_limit_flag_i),
    .high_side_cmd_o(high_side_cmd_o), .low_side_cmd_o(low_side_cmd_o),
    .fault_line_o(fault_line_o), .fault_line_oe_o(fault_line_oe_o),
    .high_side_shutdown_in_o(high_side_shutdown_in_o),
    .fault_latched_o(fault_latched_o));

// file: test/gate_driver_model.sv
module gate_driver_model (
    input wire logic [2:0] high_side_cmd_i,
    input wire logic [2:0] low_side_cmd_i,
    input wire logic high_side_shutdown_in_i,
    input wire logic ctrl_sink_i,
    input wire logic trip_i,
    input wire logic limit_i,
    input wire logic [2:0] hs_uv_i,
    output wire logic fault_line_o,
    output wire logic current_limit_flag_o,
    output wire logic [2:0] high_gate_o,
    output wire logic [2:0] low_gate_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sink = 1'b0;
    logic [2:0] hg = 3'h0;
    wire sd_f;
    // Pull-up wins unless someone sinks
    assign fault_line_o = !(sink | ctrl_sink_i);
    assign current_limit_flag_o = limit_i;
    assign low_gate_o = low_side_cmd_i & {3{fault_line_o}};
    // Inertial delay drops short pulses
    assign #3300 sd_f = high_side_shutdown_in_i;
    // High-side undervoltage drops the gate but leaves the fault line
    assign high_gate_o = hg & {3{!sd_f}} & ~hs_uv_i;
    always @(posedge trip_i) begin
        sink = 1'b1;
        #25000 sink = 1'b0;
    end
    always @(posedge sd_f) hg = 3'h0;
    for (genvar i = 0; i < 3; i++) begin : g_ph
        always @(posedge high_side_cmd_i[i]) hg[i] = 1'b1;
        always @(negedge high_side_cmd_i[i]) hg[i] = 1'b0;
    end
endmodule // gate_driver_model

// file: test/gate_ctrl_test.sv
`include "gate_ctrl_defines.vh"
module gate_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, run = 1, sreq = 0, fclr = 0, trip = 0, lim = 0;
    logic ce = 1;
    logic [2:0] hreq = 3'h5;
    wire [2:0] hcmd, lcmd, hg, lg;
    wire fo, foe, hsd, lat, busy, fline, flag;
    int error_cnt = 0, tests_run = 0;
    initial forever #4 clk = ~clk;
    gate_ctrl dut (.sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(ce),
        .run_i(run), .high_req_i(hreq), .shutdown_req_i(sreq),
        .fault_clear_i(fclr), .fault_line_i(fline),
        .current_limit_flag_i(flag), .high_side_cmd_o(hcmd),
        .low_side_cmd_o(lcmd), .fault_line_o(fo), .fault_line_oe_o(foe),
        .high_side_shutdown_in_o(hsd), .fault_latched_o(lat),
        .shutdown_busy_o(busy));
    gate_driver_model drv (.high_side_cmd_i(hcmd), .low_side_cmd_i(lcmd),
        .high_side_shutdown_in_i(hsd), .ctrl_sink_i(foe & !fo),
        .trip_i(trip), .limit_i(lim), .fault_line_o(fline),
        .current_limit_flag_o(flag), .high_gate_o(hg), .low_gate_o(lg),
        .hs_uv_i(3'h0));
    task chk(input logic c, input string m);
        tests_run++;
        if (c !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task final_report;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task t_start;
        cyc(12);
        rst_n = 1;
        cyc(`DEAD_CYC + 4);
        chk(hcmd === 3'h5 && lcmd === 3'h2, "start levels");
        $display("t_start done");
    endtask
    task t_limit;
        chk(hsd === 1'b0, "shutdown idle");
        ce = 0;
        lim = 1;
        cyc(4);
        chk(hsd === 1'b0, "frozen by enable");
        ce = 1;
        cyc(4);
        chk(hsd === 1'b1, "shutdown on limit");
        lim = 0;
        cyc(4);
        $display("t_limit done");
    endtask
    task t_swap;
        hreq = 3'h2;
        cyc(`PERIOD_CYC / 2 - `DEAD_CYC);
        chk(hcmd[0] === 1'b1, "dwell held");
        cyc(`DEAD_CYC + 300);
        chk(hcmd === 3'h2 && lcmd === 3'h5, "swapped");
        chk(hg === 3'h2, "high gates follow");
        $display("t_swap done");
    endtask
    task t_trip;
        trip = 1;
        cyc(1);
        trip = 0;
        cyc(4);
        chk(hcmd === 3'h0 && lcmd === 3'h0 && lat === 1'b1, "trip");
        cyc(3000);
        chk(lat === 1'b1 && fline === 1'b0, "hold");
        chk(lg === 3'h0, "low gates off");
        cyc(200);
        fclr = 1;
        cyc(2);
        fclr = 0;
        chk(lat === 1'b0, "clear");
        cyc(`DEAD_CYC + 4);
        chk(lcmd === 3'h5, "resume");
        run = 0;
        cyc(3);
        chk((hcmd | lcmd) === 3'h0, "run stop");
        run = 1;
        $display("t_trip done");
    endtask
    task t_force;
        sreq = 1;
        cyc(1);
        sreq = 0;
        cyc(1);
        chk(foe === 1'b1 && fline === 1'b0, "forced low");
        chk(busy === 1'b1, "busy");
        cyc(`SHDN_CYC - 4);
        chk(foe === 1'b1, "forced width");
        cyc(8);
        chk(foe === 1'b0, "forced end");
        chk(busy === 1'b0, "busy end");
        $display("t_force done");
    endtask
    initial begin
        t_start;
        t_limit;
        t_swap;
        t_trip;
        t_force;
        final_report;
    end
    // Run needs about 62 us of stimulus
    initial begin
        #200000;
        error_cnt++;
        $display("MISMATCH %0t watchdog", $time);
        final_report;
    end
endmodule // gate_ctrl_test
